// file: hw/fei_pkg.sv
// types shared by the flash erase and info read block
// assumes nothing beyond a SystemVerilog compiler
package fei_pkg;

    typedef enum logic [1:0] {
        FEI_OP_READ = 2'b00,
        FEI_OP_PROG = 2'b01,
        FEI_OP_PAGE = 2'b10,
        FEI_OP_MASS = 2'b11
    } fei_op_t;

    typedef enum logic [1:0] {
        FEI_ST_IDLE = 2'b01,
        FEI_ST_BUSY = 2'b10
    } fei_state_t;

    typedef enum logic [1:0] {
        FEI_RG_CODE = 2'b00,
        FEI_RG_DATA = 2'b01,
        FEI_RG_INFO = 2'b10
    } fei_region_t;

    typedef struct packed {
        logic        start;
        logic        mass;
        fei_region_t region;
        logic [14:0] addr;
    } fei_erase_cmd_t;

    typedef struct packed {
        logic        req;
        fei_region_t region;
        logic [14:0] addr;
    } fei_rd_req_t;

endpackage

// file: hw/fei_regs.svh
// register offsets, field positions, reset values and erase timing
// assumes the including file supplies the clock rate below unchanged
`ifndef FEI_REGS_SVH
`define FEI_REGS_SVH

`define FEI_CLK_MHZ        250
`define FEI_MASS_MS        200
`define FEI_PAGE_DATA_MS   2
`define FEI_PAGE_CODE_MS   20
`define FEI_MASS_CYC       (`FEI_MASS_MS * `FEI_CLK_MHZ * 1000)
`define FEI_PAGE_DATA_CYC  (`FEI_PAGE_DATA_MS * `FEI_CLK_MHZ * 1000)
`define FEI_PAGE_CODE_CYC  (`FEI_PAGE_CODE_MS * `FEI_CLK_MHZ * 1000)

`define FEI_OFS_CTRL       8'h00
`define FEI_OFS_CFG        8'h04
`define FEI_OFS_SPACE      8'h08
`define FEI_OFS_IADDR      8'h0C
`define FEI_OFS_IDATA      8'h10

`define FEI_CTRL_MAP_BIT   7
`define FEI_CTRL_OP_LSB    5
`define FEI_CTRL_BUSY_BIT  2
`define FEI_CFG_DFS_LSB    5
`define FEI_CFG_CWU_BIT    1
`define FEI_CFG_BAU_BIT    0
`define FEI_RESET_BYTE     8'h00

`define FEI_CODE_TOP       16'h5FFF
`define FEI_BOOT_LIMIT     16'h1000
`define FEI_DPM_LO         16'h6000
`define FEI_DPM_HI         16'h7FFF
`define FEI_DDM_LO         16'h4000
`define FEI_DDM_HI         16'h5FFF
`define FEI_INFO_LO        16'h8000
`define FEI_INFO_HI        16'h803F
`define FEI_DFS_DM         3'h7

`endif

// file: hw/fei_top.sv
// flash erase sequencer and info section read path, APB slave registers
// assumes the flash array answers a read one cycle after the request
// and carries out an erase on the start pulse; all inputs synchronous
//
// Notes on behaviour
// - unmapped info range direct read returns zero
// - info address register fetches info byte while unmapped
// - info registers never write flash
// - mapped info section readable by code reads
// - mass code plus write starts mass erase
// - program code range erases whole code
// - upper program range erases data if dfs0xx
// - mapped info range mass erases info
// - program mass erase needs both unlocks
// - data window mass erases data memory
// - busy spans erase; op returns read-only
// - mass erase busy at least 200 ms
// - page code erases addressed page only
// - pages 64 data, 512 code, info one
// - code range page erases 512 byte page
// - upper range data page needs dfs zero
// - mapped info range page erases info
// - program page erase refused without code unlock
// - boot lock protects lowest 4K only
// - data window page erases 64 bytes
// - page erase 2 ms data, 20 ms code
// - space select picks data or program
// - op zero starts no operation
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "fei_regs.svh"

module fei_top
    import fei_pkg::*;
#(
    parameter int unsigned MASS_CYC      = `FEI_MASS_CYC,
    parameter int unsigned PAGE_DATA_CYC = `FEI_PAGE_DATA_CYC,
    parameter int unsigned PAGE_CODE_CYC = `FEI_PAGE_CODE_CYC
) (
    input  wire logic           clock_i,
    input  wire logic           resetn_i,
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [7:0]     paddr_i,
    input  wire logic [31:0]    pwdata_i,
    input  wire logic [3:0]     pstrb_i,
    output logic      [31:0]    prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    input  wire logic           xdata_wr_i,
    input  wire logic [15:0]    xdata_addr_i,
    input  wire logic           code_rd_i,
    input  wire logic [15:0]    code_addr_i,
    output logic      [7:0]     code_data_o,
    output logic                code_valid_o,
    output fei_rd_req_t         flash_rd_o,
    input  wire logic [7:0]     flash_rd_data_i,
    output fei_erase_cmd_t      erase_cmd_o,
    output logic                busy_o
);

    logic        info_map_reg;
    fei_op_t     op_reg;
    logic [2:0]  dfs_reg;
    logic        cwu_reg;
    logic        bau_reg;
    logic        space_reg;
    logic [7:0]  iaddr_reg;
    logic [7:0]  idata_reg;
    fei_state_t  state_reg;
    logic [31:0] cnt_reg;
    logic        pend_reg;

    // apb: first access cycle prepares, second completes
    logic apb_prep;
    logic apb_done;
    logic apb_wr;
    logic apb_map;
    logic [31:0] rd_next;
    assign apb_prep = psel_i & penable_i & ~pready_o;
    assign apb_done = psel_i & penable_i & pready_o;
    assign apb_wr   = apb_done & pwrite_i & pstrb_i[0] & ~pslverr_o;

    always_comb begin
        rd_next = 32'h0000_0000;
        apb_map = 1'b1;
        case (paddr_i)
            `FEI_OFS_CTRL: begin
                rd_next[`FEI_CTRL_MAP_BIT] = info_map_reg;
                rd_next[`FEI_CTRL_OP_LSB +: 2] = op_reg;
                rd_next[`FEI_CTRL_BUSY_BIT] = busy_o;
            end
            `FEI_OFS_CFG: begin
                rd_next[`FEI_CFG_DFS_LSB +: 3] = dfs_reg;
                rd_next[`FEI_CFG_CWU_BIT] = cwu_reg;
                rd_next[`FEI_CFG_BAU_BIT] = bau_reg;
            end
            `FEI_OFS_SPACE: rd_next[0] = space_reg;
            `FEI_OFS_IADDR: rd_next[7:0] = iaddr_reg;
            `FEI_OFS_IDATA: rd_next[7:0] = idata_reg;
            default: apb_map = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (apb_prep) begin
            pready_o  <= 1'b1;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_next;
            pslverr_o <= ~apb_map;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // erase request decode
    logic        is_mass;
    logic        is_erase;
    logic        hit;
    logic        start;
    logic        done;
    fei_region_t dec_region;
    logic [14:0] dec_addr;
    logic [31:0] dec_dur;
    logic [15:0] xa;
    assign xa       = xdata_addr_i;
    assign is_mass  = (op_reg == FEI_OP_MASS);
    assign is_erase = (op_reg == FEI_OP_MASS) | (op_reg == FEI_OP_PAGE);
    assign start    = xdata_wr_i & is_erase & hit & (state_reg == FEI_ST_IDLE);
    assign done     = (state_reg == FEI_ST_BUSY) & (cnt_reg == 32'h0000_0000);

    always_comb begin
        hit        = 1'b0;
        dec_region = FEI_RG_CODE;
        dec_addr   = 15'h0000;
        if (space_reg) begin
            if (xa <= `FEI_CODE_TOP) begin
                dec_region = FEI_RG_CODE;
                dec_addr   = {xa[14:9], 9'h000};
                // boot lock only guards the lowest 4K on page erase
                hit = is_mass ? (cwu_reg & bau_reg)
                              : (cwu_reg & (bau_reg | (xa >= `FEI_BOOT_LIMIT)));
            end else if ((xa >= `FEI_DPM_LO) && (xa <= `FEI_DPM_HI)) begin
                dec_region = FEI_RG_DATA;
                dec_addr   = {2'b00, xa[12:6], 6'h00};
                hit = is_mass ? (cwu_reg & bau_reg & ~dfs_reg[2])
                              : (cwu_reg & (dfs_reg == 3'h0));
            end else if ((xa >= `FEI_INFO_LO) && (xa <= `FEI_INFO_HI)) begin
                dec_region = FEI_RG_INFO;
                hit = info_map_reg & cwu_reg & (bau_reg | ~is_mass);
            end
        end else if ((dfs_reg == `FEI_DFS_DM) && (xa >= `FEI_DDM_LO) && (xa <= `FEI_DDM_HI)) begin
            dec_region = FEI_RG_DATA;
            dec_addr   = {2'b00, xa[12:6], 6'h00};
            hit        = 1'b1;
        end
        if (is_mass) begin
            dec_addr = 15'h0000;
        end
    end

    always_comb begin
        if (is_mass) begin
            dec_dur = MASS_CYC;
        end else if (dec_region == FEI_RG_CODE) begin
            dec_dur = PAGE_CODE_CYC;
        end else begin
            dec_dur = PAGE_DATA_CYC;
        end
    end

    // erase sequencer
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= FEI_ST_IDLE;
            cnt_reg   <= 32'h0000_0000;
        end else begin
            case (state_reg)
                FEI_ST_IDLE: begin
                    if (start) begin
                        state_reg <= FEI_ST_BUSY;
                        cnt_reg   <= dec_dur - 32'h0000_0001;
                    end
                end
                FEI_ST_BUSY: begin
                    if (done) begin
                        state_reg <= FEI_ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 32'h0000_0001;
                    end
                end
                default: state_reg <= FEI_ST_IDLE;
            endcase
        end
    end
    assign busy_o = state_reg[1];

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            erase_cmd_o <= '0;
        end else if (start) begin
            erase_cmd_o.start  <= 1'b1;
            erase_cmd_o.mass   <= is_mass;
            erase_cmd_o.region <= dec_region;
            erase_cmd_o.addr   <= dec_addr;
        end else begin
            erase_cmd_o.start <= 1'b0;
        end
    end

    // control registers; op field is owned by hardware while busy
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            info_map_reg <= 1'b0;
            op_reg       <= FEI_OP_READ;
        end else begin
            if (apb_wr && (paddr_i == `FEI_OFS_CTRL)) begin
                info_map_reg <= pwdata_i[`FEI_CTRL_MAP_BIT];
            end
            if (done) begin
                op_reg <= FEI_OP_READ;
            end else if (apb_wr && (paddr_i == `FEI_OFS_CTRL) && !busy_o) begin
                op_reg <= fei_op_t'(pwdata_i[`FEI_CTRL_OP_LSB +: 2]);
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dfs_reg   <= 3'h0;
            cwu_reg   <= 1'b0;
            bau_reg   <= 1'b0;
            space_reg <= 1'b0;
        end else if (apb_wr && (paddr_i == `FEI_OFS_CFG)) begin
            dfs_reg <= pwdata_i[`FEI_CFG_DFS_LSB +: 3];
            cwu_reg <= pwdata_i[`FEI_CFG_CWU_BIT];
            bau_reg <= pwdata_i[`FEI_CFG_BAU_BIT];
        end else if (apb_wr && (paddr_i == `FEI_OFS_SPACE)) begin
            space_reg <= pwdata_i[0];
        end
    end

    // info address write queues a fetch while info is unmapped; data register is read-only
    logic iaddr_wr;
    logic info_issue;
    assign iaddr_wr   = apb_wr & (paddr_i == `FEI_OFS_IADDR);
    assign info_issue = pend_reg & ~code_rd_i;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            iaddr_reg <= `FEI_RESET_BYTE;
            pend_reg  <= 1'b0;
        end else begin
            if (iaddr_wr) begin
                iaddr_reg <= pwdata_i[7:0];
            end
            if (iaddr_wr && !info_map_reg) begin
                pend_reg <= 1'b1;
            end else if (info_issue) begin
                pend_reg <= 1'b0;
            end
        end
    end

    // read pipeline: s1 drives the array, s2 takes its answer
    // code reads win the port; a pending info fetch waits until code_rd_i is low
    logic        c_info;
    logic        c_zero;
    fei_region_t c_region;
    logic        s1_code_reg;
    logic        s1_info_reg;
    logic        s1_zero_reg;
    logic        s2_code_reg;
    logic        s2_info_reg;
    logic        s2_zero_reg;
    assign c_info = (code_addr_i >= `FEI_INFO_LO) && (code_addr_i <= `FEI_INFO_HI);

    always_comb begin
        c_zero   = 1'b0;
        c_region = FEI_RG_CODE;
        if (c_info) begin
            c_region = FEI_RG_INFO;
            c_zero   = ~info_map_reg;
        end else if (code_addr_i > `FEI_DPM_HI) begin
            c_zero = 1'b1;
        end else if (code_addr_i >= `FEI_DPM_LO) begin
            c_region = FEI_RG_DATA;
            c_zero   = dfs_reg[2];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flash_rd_o  <= '0;
            s1_code_reg <= 1'b0;
            s1_info_reg <= 1'b0;
            s1_zero_reg <= 1'b0;
        end else begin
            s1_code_reg <= code_rd_i;
            s1_info_reg <= info_issue;
            if (code_rd_i) begin
                flash_rd_o.req    <= ~c_zero;
                flash_rd_o.region <= c_region;
                flash_rd_o.addr   <= c_info ? {9'h000, code_addr_i[5:0]} : code_addr_i[14:0];
                s1_zero_reg       <= c_zero;
            end else if (info_issue) begin
                // only the 64 info bytes can be reached
                flash_rd_o.req    <= (iaddr_reg[7:6] == 2'b00);
                flash_rd_o.region <= FEI_RG_INFO;
                flash_rd_o.addr   <= {9'h000, iaddr_reg[5:0]};
                s1_zero_reg       <= (iaddr_reg[7:6] != 2'b00);
            end else begin
                flash_rd_o.req <= 1'b0;
                s1_zero_reg    <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s2_code_reg  <= 1'b0;
            s2_info_reg  <= 1'b0;
            s2_zero_reg  <= 1'b0;
            code_valid_o <= 1'b0;
            code_data_o  <= 8'h00;
            idata_reg    <= `FEI_RESET_BYTE;
        end else begin
            s2_code_reg  <= s1_code_reg;
            s2_info_reg  <= s1_info_reg;
            s2_zero_reg  <= s1_zero_reg;
            code_valid_o <= s2_code_reg;
            if (s2_code_reg) begin
                code_data_o <= s2_zero_reg ? 8'h00 : flash_rd_data_i;
            end
            if (s2_info_reg) begin
                idata_reg <= s2_zero_reg ? 8'h00 : flash_rd_data_i;
            end
        end
    end

    // checks
    logic [31:0] busy_len;
    logic        last_mass;
    logic        last_code;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_len  <= 32'h0000_0000;
            last_mass <= 1'b0;
            last_code <= 1'b0;
        end else if (start) begin
            busy_len  <= 32'h0000_0000;
            last_mass <= is_mass;
            last_code <= (dec_region == FEI_RG_CODE);
        end else if (busy_o) begin
            busy_len <= busy_len + 32'h0000_0001;
        end
    end

    a_info_zero_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (code_rd_i && c_info && !info_map_reg) |-> ##3 (code_valid_o && code_data_o == 8'h00))
        else $error("unmapped info read not zero");
    a_info_mapped_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (code_rd_i && c_info && info_map_reg) |=> (flash_rd_o.req && flash_rd_o.region == FEI_RG_INFO))
        else $error("mapped info read not issued");
    a_start_sets_busy: assert property (@(posedge clock_i) disable iff (!resetn_i)
        start |=> (busy_o && erase_cmd_o.start) ##1 !erase_cmd_o.start)
        else $error("erase start without busy");
    a_done_clears_op: assert property (@(posedge clock_i) disable iff (!resetn_i)
        $fell(busy_o) |-> (op_reg == FEI_OP_READ))
        else $error("op not cleared at end");
    a_mass_min_time: assert property (@(posedge clock_i) disable iff (!resetn_i)
        ($fell(busy_o) && last_mass) |-> (busy_len >= MASS_CYC))
        else $error("mass erase too short");
    a_page_min_time: assert property (@(posedge clock_i) disable iff (!resetn_i)
        ($fell(busy_o) && !last_mass) |-> (busy_len >= (last_code ? PAGE_CODE_CYC : PAGE_DATA_CYC)))
        else $error("page erase too short");
    a_lock_refuse: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (xdata_wr_i && space_reg && is_mass && !(cwu_reg && bau_reg)) |=> !erase_cmd_o.start)
        else $error("locked mass erase started");
    a_boot_refuse: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (xdata_wr_i && space_reg && !is_mass && !bau_reg && xa < `FEI_BOOT_LIMIT) |=> !erase_cmd_o.start)
        else $error("boot page erased while locked");
    a_busy_ignore: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (busy_o && xdata_wr_i) |=> !erase_cmd_o.start)
        else $error("write accepted while busy");
    a_readonly_op: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (xdata_wr_i && !is_erase) |=> (!erase_cmd_o.start && $stable(busy_o)))
        else $error("erase started in read-only op");
    a_dm_window: assert property (@(posedge clock_i) disable iff (!resetn_i)
        (xdata_wr_i && is_mass && !busy_o && !space_reg && dfs_reg == `FEI_DFS_DM
         && xa >= `FEI_DDM_LO && xa <= `FEI_DDM_HI)
        |=> (erase_cmd_o.start && erase_cmd_o.mass && erase_cmd_o.region == FEI_RG_DATA))
        else $error("data window mass erase missed");

    c_mass_erase: cover property (@(posedge clock_i) disable iff (!resetn_i)
        start && is_mass);
    c_page_erase: cover property (@(posedge clock_i) disable iff (!resetn_i)
        start && !is_mass);
    c_info_fetch: cover property (@(posedge clock_i) disable iff (!resetn_i)
        s2_info_reg && !s2_zero_reg);
    c_refused: cover property (@(posedge clock_i) disable iff (!resetn_i)
        xdata_wr_i && is_erase && !busy_o && !hit);

endmodule

// file: verif/fei_flash_model.sv
// flash array stand-in that answers the block's read requests
// assumes requests arrive as single-cycle pulses on clock_i
`timescale 1ns/100ps
module fei_flash_model
    import fei_pkg::*;
(
    input  wire logic        clock_i,
    input  wire fei_rd_req_t rd_req_i,
    output logic [7:0]       rd_data_o = 8'h00
);
    // answer stands one cycle, then toggles so that stale data never looks valid
    always @(posedge clock_i) begin
        if (rd_req_i.req) begin
            rd_data_o <= rd_req_i.addr[7:0] ^ 8'h5A ^ {6'h00, rd_req_i.region};
        end else begin
            rd_data_o <= ~rd_data_o;
        end
    end
endmodule

// file: verif/tb.sv
// self-checking bench for the flash erase and info read block
// assumes shortened erase counts and the flash stand-in model
`timescale 1ns/100ps
`include "fei_regs.svh"
module tb
    import fei_pkg::*;
;
    localparam int MC = 40;
    localparam int CC = 20;
    localparam int DC = 10;
    logic           clock_i, resetn_i, psel, penable, pwrite, xwr, crd_s;
    logic [7:0]     paddr, fdata, cdata;
    logic [31:0]    pwdata, prdata;
    logic [15:0]    xaddr, caddr;
    logic           pready, pslverr, cvalid, busy;
    logic [1:0]     cur_op;
    fei_rd_req_t    rdreq;
    fei_erase_cmd_t ecmd;
    int             num_errors = 0;
    int             checks = 0;

    fei_top #(.MASS_CYC(MC), .PAGE_DATA_CYC(DC), .PAGE_CODE_CYC(CC)) fei_top_i (
        .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .xdata_wr_i(xwr), .xdata_addr_i(xaddr), .code_rd_i(crd_s), .code_addr_i(caddr),
        .code_data_o(cdata), .code_valid_o(cvalid), .flash_rd_o(rdreq),
        .flash_rd_data_i(fdata), .erase_cmd_o(ecmd), .busy_o(busy));
    fei_flash_model fei_flash_model_i (.clock_i(clock_i), .rd_req_i(rdreq), .rd_data_o(fdata));

    function automatic logic [7:0] fdat(input fei_region_t r, input logic [15:0] a);
        return a[7:0] ^ 8'h5A ^ {6'h00, r};
    endfunction

    task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", w, exp, seen);
        end
    endtask

    // holds the whole request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        // values read here are those the slave saw at this edge
        @(posedge clock_i);
        while (pready !== 1'b1) begin
            @(posedge clock_i);
            n++;
        end
        chk("apb wait states", n, 1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {24'h000000, d}, q, e);
    endtask

    task automatic rd(input string w, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h00000000, q, e);
        chk(w, q, x);
    endtask

    task automatic cfg(input logic sp, input logic [7:0] cf, input logic [7:0] ct);
        wr(`FEI_OFS_SPACE, {7'h00, sp});
        wr(`FEI_OFS_CFG, cf);
        wr(`FEI_OFS_CTRL, ct);
        cur_op = ct[6:5];
    endtask

    task automatic cread(input string w, input logic [15:0] a, input logic [7:0] x);
        @(posedge clock_i);
        crd_s <= 1'b1;
        caddr <= a;
        @(posedge clock_i);
        crd_s <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        chk(w, {cvalid, cdata}, {1'b1, x});
    endtask

    // a second write is fired mid-erase; it must start nothing
    task automatic erase(input string w, input logic [15:0] a, input logic ok,
                         input logic [18:0] cmd, input int len);
        int          n;
        int          st;
        logic [31:0] q;
        logic        e;
        n = 0;
        st = 0;
        @(posedge clock_i);
        xwr <= 1'b1;
        xaddr <= a;
        @(posedge clock_i);
        xwr <= 1'b0;
        #1;
        chk(w, {busy, ecmd.start}, {ok, ok});
        if (ok) begin
            chk(w, ecmd, cmd);
        end
        while (busy === 1'b1 && n < 100) begin
            @(posedge clock_i);
            xwr <= (n == 1);
            #1;
            n++;
            st += ecmd.start;
        end
        chk(w, n, ok ? len : 0);
        chk(w, st, 0);
        apb(1'b0, `FEI_OFS_CTRL, 32'h00000000, q, e);
        chk(w, q[6:2], {(ok ? 2'b00 : cur_op), 3'b000});
        cur_op = q[6:5];
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        rd("ctrl reset", `FEI_OFS_CTRL, 32'h00000000);
        apb(1'b1, 8'h14, 32'h000000FF, q, e);
        chk("unmapped error", e, 1'b1);
        rd("ctrl kept", `FEI_OFS_CTRL, 32'h00000000);
        $display("test reset done");
    endtask

    task automatic t_info();
        cread("info direct unmapped", 16'h8005, 8'h00);
        cread("code byte", 16'h0123, fdat(FEI_RG_CODE, 16'h0123));
        wr(`FEI_OFS_IADDR, 8'h05);
        repeat (6) @(posedge clock_i);
        rd("info data", `FEI_OFS_IDATA, fdat(FEI_RG_INFO, 16'h0005));
        wr(`FEI_OFS_IDATA, 8'hFF);
        rd("info data kept", `FEI_OFS_IDATA, fdat(FEI_RG_INFO, 16'h0005));
        wr(`FEI_OFS_IADDR, 8'h40);
        repeat (6) @(posedge clock_i);
        rd("info past end", `FEI_OFS_IDATA, 32'h00000000);
        cfg(1'b0, 8'h00, 8'h80);
        cread("info direct mapped", 16'h803F, fdat(FEI_RG_INFO, 16'h003F));
        $display("test info done");
    endtask

    // op is rewritten before every erase, as software must
    task automatic t_mass();
        cfg(1'b1, 8'h03, 8'h60);
        erase("mass code", 16'h1234, 1'b1, {2'b11, FEI_RG_CODE, 15'h0000}, MC);
        cfg(1'b1, 8'h63, 8'h60);
        erase("mass data upper", 16'h7000, 1'b1, {2'b11, FEI_RG_DATA, 15'h0000}, MC);
        cfg(1'b1, 8'h03, 8'hE0);
        erase("mass info", 16'h8010, 1'b1, {2'b11, FEI_RG_INFO, 15'h0000}, MC);
        cfg(1'b1, 8'h02, 8'h60);
        erase("mass boot locked", 16'h2000, 1'b0, 19'h00000, 0);
        cfg(1'b1, 8'h01, 8'h60);
        erase("mass code locked", 16'h2000, 1'b0, 19'h00000, 0);
        cfg(1'b0, 8'hE0, 8'h60);
        erase("mass data window", 16'h5000, 1'b1, {2'b11, FEI_RG_DATA, 15'h0000}, MC);
        $display("test mass done");
    endtask

    task automatic t_page();
        cfg(1'b1, 8'h03, 8'h40);
        erase("page code", 16'h1234, 1'b1, {2'b10, FEI_RG_CODE, 15'h1200}, CC);
        cfg(1'b1, 8'h63, 8'h40);
        erase("page data map off", 16'h7000, 1'b0, 19'h00000, 0);
        cfg(1'b1, 8'h03, 8'h40);
        erase("page data upper", 16'h7FC5, 1'b1, {2'b10, FEI_RG_DATA, 15'h1FC0}, DC);
        cfg(1'b1, 8'h03, 8'hC0);
        erase("page info", 16'h803F, 1'b1, {2'b10, FEI_RG_INFO, 15'h0000}, DC);
        cfg(1'b1, 8'h01, 8'h40);
        erase("page code locked", 16'h2000, 1'b0, 19'h00000, 0);
        cfg(1'b1, 8'h02, 8'h40);
        erase("page boot area", 16'h0FFF, 1'b0, 19'h00000, 0);
        erase("page above boot", 16'h1000, 1'b1, {2'b10, FEI_RG_CODE, 15'h1000}, CC);
        cfg(1'b0, 8'hE0, 8'h40);
        erase("page data space low", 16'h1234, 1'b0, 19'h00000, 0);
        erase("page data window", 16'h5FFF, 1'b1, {2'b10, FEI_RG_DATA, 15'h1FC0}, DC);
        cfg(1'b1, 8'h03, 8'h00);
        erase("read only op", 16'h1234, 1'b0, 19'h00000, 0);
        cfg(1'b1, 8'h03, 8'h20);
        erase("program op", 16'h1234, 1'b0, 19'h00000, 0);
        cfg(1'b1, 8'h03, 8'h40);
        erase("page unmapped", 16'h9000, 1'b0, 19'h00000, 0);
        $display("test page done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    initial begin
        resetn_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        xwr = 1'b0;
        xaddr = 16'h0000;
        crd_s = 1'b0;
        caddr = 16'h0000;
        cur_op = 2'b00;
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        t_reset();
        t_info();
        t_mass();
        t_page();
        wrap_up();
    end

    // the whole run needs well under a thousand cycles; this cuts a hang short
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
endmodule
